// ---- hw/pbs_sram_port.sv ----
// Purpose: Pipelined burst SRAM port with no bus turnaround cycles.
// Assumes: Controller pins are asynchronous to clock and pass two flip-flops first.
// Notes: Cycle numbers below count from the edge at which the synchronised command is seen.
// Operation
// - Burst advances only the two low address bits.
// - A load ends any running burst.
// - Read/write select ignored while advancing.
// - Burst direction fixed at load time.
// - Write starts on load with select low.
// - Byte enables lead their write data two cycles.
// - Suspend edge holds every register past the synchronisers.
// - Any inactive select starts a deselect cycle.
// - Pending transfers finish, then bus floats.
// - Selected only when all three selects active.
// - Read data driven two cycles after command.
// - Data bus undriven from reset until read.
`timescale 1ns/10ps
module pbs_sram_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic [pbs_pkg::ADDR_W-1:0] address,
    input wire logic read_write_n,
    input wire logic advance_or_load,
    input wire logic chip_select_first_n,
    input wire logic chip_select_positive,
    input wire logic chip_select_second_n,
    input wire logic clock_suspend_n,
    input wire logic [pbs_pkg::BYTES-1:0] byte_write_enable_n,
    input wire logic burst_order_select_n,
    input wire logic [pbs_pkg::DATA_W-1:0] data_in,
    output logic [pbs_pkg::DATA_W-1:0] data_out,
    output logic data_out_en
);
    import pbs_pkg::*;
    // Address, six single-bit controls, byte enables, burst order and data.
    localparam int SYNC_W = ADDR_W + 6 + BYTES + 1 + DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the second stage is the only one read by logic.
    logic [SYNC_W-1:0] pins, meta_q, sync_q;
    logic [ADDR_W-1:0] s_addr;
    logic s_rw_n, s_adv, s_ce1_n, s_ce2, s_ce2_n, s_susp;
    logic [BYTES-1:0] s_bwe_n;
    logic s_lbo_n;
    logic [DATA_W-1:0] s_din;

    assign pins = {address, read_write_n, advance_or_load, chip_select_first_n, chip_select_positive,
                   chip_select_second_n, clock_suspend_n, byte_write_enable_n, burst_order_select_n, data_in};
    assign {s_addr, s_rw_n, s_adv, s_ce1_n, s_ce2, s_ce2_n, s_susp, s_bwe_n, s_lbo_n, s_din} = sync_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode.
    logic fifo_in_ready, fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic hold, go, selected, load, advance;
    logic base_rd_q, base_rd_d, active_q, active_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [BURST_W-1:0] cnt_q, cnt_d, cur_cnt, low_bits;
    logic [ADDR_W-1:0] cur_base, op_addr;
    logic op_rd, op_wr;

    // suspend freezes state
    // A full read queue also stalls, so no read word is ever dropped.
    assign hold = s_susp | ~fifo_in_ready;
    assign go = ~hold;
    assign selected = ~s_ce1_n & s_ce2 & ~s_ce2_n;
    assign load = selected & ~s_adv;
    assign advance = selected & s_adv & active_q;

    assign cur_base = load ? s_addr : base_q;
    assign cur_cnt = load ? BURST_START : cnt_q + BURST_STEP;
    assign low_bits = s_lbo_n ? (cur_base[BURST_W-1:0] ^ cur_cnt) : (cur_base[BURST_W-1:0] + cur_cnt);
    assign op_addr = {cur_base[ADDR_W-1:BURST_W], low_bits};
    assign op_rd = (load & s_rw_n) | (advance & base_rd_q);
    assign op_wr = (load & ~s_rw_n) | (advance & ~base_rd_q);

    always_comb begin
        base_d = base_q;
        cnt_d = cnt_q;
        base_rd_d = base_rd_q;
        active_d = active_q;
        if (go) begin
            if (!selected) begin
                active_d = 1'b0;
            end else if (!s_adv) begin
                base_d = s_addr;
                cnt_d = BURST_START;
                base_rd_d = s_rw_n;
                active_d = 1'b1;
            end else if (active_q) begin
                cnt_d = cnt_q + BURST_STEP;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            base_q <= '0;
            cnt_q <= BURST_START;
            base_rd_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            base_q <= base_d;
            cnt_q <= cnt_d;
            base_rd_q <= base_rd_d;
            active_q <= active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pipeline: stage one holds the command, stage two the write awaiting data.
    logic p1_rd_q, p1_rd_d, p1_wr_q, p1_wr_d, p2_wr_q, p2_wr_d;
    logic [ADDR_W-1:0] p1_addr_q, p1_addr_d, p2_addr_q, p2_addr_d;
    logic [BYTES-1:0] p1_be_q, p1_be_d, p2_be_q, p2_be_d;
    logic [DATA_W-1:0] dout_d;
    logic oe_d;

    always_comb begin
        p1_rd_d = p1_rd_q;
        p1_wr_d = p1_wr_q;
        p1_addr_d = p1_addr_q;
        p1_be_d = p1_be_q;
        p2_wr_d = p2_wr_q;
        p2_addr_d = p2_addr_q;
        p2_be_d = p2_be_q;
        oe_d = data_out_en;
        dout_d = data_out;
        if (go) begin
            p1_rd_d = op_rd;
            p1_wr_d = op_wr;
            p1_addr_d = op_addr;
            p1_be_d = ~s_bwe_n;
            p2_wr_d = p1_wr_q;
            p2_addr_d = p1_addr_q;
            p2_be_d = p1_be_q;
            oe_d = p1_rd_q;
            if (p1_rd_q) begin
                dout_d = fifo_out_data;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            p1_rd_q <= 1'b0;
            p1_wr_q <= 1'b0;
            p1_addr_q <= '0;
            p1_be_q <= '0;
            p2_wr_q <= 1'b0;
            p2_addr_q <= '0;
            p2_be_q <= '0;
            data_out <= '0;
            data_out_en <= 1'b0;
        end else begin
            p1_rd_q <= p1_rd_d;
            p1_wr_q <= p1_wr_d;
            p1_addr_q <= p1_addr_d;
            p1_be_q <= p1_be_d;
            p2_wr_q <= p2_wr_d;
            p2_addr_q <= p2_addr_d;
            p2_be_q <= p2_be_d;
            data_out <= dout_d;
            data_out_en <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage. A write to the address read one cycle later is not forwarded, since its data has not arrived.
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] old_word, wr_word, rd_word;

    assign old_word = mem[p2_addr_q];
    genvar b;
    generate
        for (b = 0; b < BYTES; b++) begin : g_lane
            assign wr_word[b*LANE_W +: LANE_W] = p2_be_q[b] ? s_din[b*LANE_W +: LANE_W]
                                                            : old_word[b*LANE_W +: LANE_W];
        end
    endgenerate
    assign rd_word = (p2_wr_q && p2_addr_q == op_addr) ? wr_word : mem[op_addr];

    always_ff @(posedge clock) begin
        if (!rst && go && p2_wr_q) begin
            mem[p2_addr_q] <= wr_word;
        end
    end

    pbs_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_read_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(op_rd & go),
        .in_ready(fifo_in_ready),
        .in_data(rd_word),
        .out_valid(fifo_out_valid),
        .out_ready(p1_rd_q & go),
        .out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [BURST_W-1:0] lin_next;
    assign lin_next = base_q[BURST_W-1:0] + cnt_q + BURST_STEP;
    logic [BURST_W-1:0] int_next;
    assign int_next = base_q[BURST_W-1:0] ^ (cnt_q + BURST_STEP);

    AST_BURST_HIGH_BITS: assert property (@(posedge clock) disable iff (rst)
        advance && go |=> p1_addr_q[ADDR_W-1:BURST_W] == $past(base_q[ADDR_W-1:BURST_W]))
        else $error("Burst changed upper address bits.");
    AST_LOAD_RESTART: assert property (@(posedge clock) disable iff (rst)
        load && go |=> cnt_q == BURST_START && active_q && base_q == $past(s_addr))
        else $error("Load did not restart the burst.");
    AST_ADVANCE_KEEPS_DIR: assert property (@(posedge clock) disable iff (rst)
        advance && go |=> p1_rd_q == $past(base_rd_q) && p1_wr_q == !$past(base_rd_q))
        else $error("Advance took direction from select pin.");
    AST_DIR_CAPTURED: assert property (@(posedge clock) disable iff (rst)
        load && go |=> base_rd_q == $past(s_rw_n))
        else $error("Burst direction not captured at load.");
    AST_WRITE_START: assert property (@(posedge clock) disable iff (rst)
        load && go && !s_rw_n |=> p1_wr_q && !p1_rd_q)
        else $error("Write not started on load.");
    AST_BE_TWO_LATER: assert property (@(posedge clock) disable iff (rst)
        load && go && !s_rw_n ##1 go |=> p2_wr_q && p2_be_q == ~$past(s_bwe_n, 2))
        else $error("Byte enables not carried two cycles.");
    AST_SUSPEND_HOLD: assert property (@(posedge clock) disable iff (rst)
        hold |=> $stable(base_q) && $stable(cnt_q) && $stable(p1_addr_q) && $stable(data_out_en))
        else $error("State changed on a suspended edge.");
    AST_DESELECT: assert property (@(posedge clock) disable iff (rst)
        !selected && go |=> !p1_rd_q && !p1_wr_q && !active_q)
        else $error("Operation accepted while deselected.");
    AST_FLOAT_AFTER: assert property (@(posedge clock) disable iff (rst)
        !selected && go ##1 go |=> !data_out_en)
        else $error("Bus not released two cycles after deselect.");
    AST_READ_TWO: assert property (@(posedge clock) disable iff (rst)
        op_rd && go ##1 go |=> data_out_en)
        else $error("Read data not driven two cycles later.");
    AST_DRIVE_CAUSE: assert property (@(posedge clock) disable iff (rst)
        $rose(data_out_en) |-> $past(p1_rd_q))
        else $error("Bus driven without a read.");
    AST_LINEAR_ORDER: assert property (@(posedge clock) disable iff (rst)
        advance && go && !s_lbo_n |=> p1_addr_q[BURST_W-1:0] == $past(lin_next))
        else $error("Linear burst order wrong.");
    AST_INTERLEAVED_ORDER: assert property (@(posedge clock) disable iff (rst)
        advance && go && s_lbo_n |=> p1_addr_q[BURST_W-1:0] == $past(int_next))
        else $error("Interleaved burst order wrong.");
    // Written from the synchronised selects, not from selected, so a wrong select decode cannot hide behind itself.
    AST_SELECT_POLARITY: assert property (@(posedge clock) disable iff (rst)
        (s_ce1_n || !s_ce2 || s_ce2_n) && go |=> !p1_rd_q && !p1_wr_q)
        else $error("Operation accepted with a select inactive.");
    AST_READ_HEAD_READY: assert property (@(posedge clock) disable iff (rst)
        p1_rd_q |-> fifo_out_valid)
        else $error("Read stage holds no queued word.");
    AST_NO_BURST_ADV: assert property (@(posedge clock) disable iff (rst)
        selected && s_adv && !active_q && go |=> !p1_rd_q && !p1_wr_q)
        else $error("Advance without burst started an operation.");

    COV_READ_BURST: cover property (@(posedge clock) disable iff (rst) load && s_rw_n && go ##1 advance [*3]);
    COV_WRITE: cover property (@(posedge clock) disable iff (rst) p2_wr_q && go);
    COV_SUSPEND: cover property (@(posedge clock) disable iff (rst) data_out_en && s_susp);
    COV_DESELECT: cover property (@(posedge clock) disable iff (rst) data_out_en && !selected);
endmodule : pbs_sram_port

// ---- hw/pbs_pkg.sv ----
// Purpose: Shared constants for the pipelined burst SRAM port.
// Assumes: One clock at 200 MHz, synchronous active-high reset.
// Notes: Byte lanes are DATA_W / BYTES bits wide.
package pbs_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 36;
    localparam int BYTES = 4;
    localparam int LANE_W = DATA_W / BYTES;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int DATA_LATENCY = 2;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
endpackage : pbs_pkg

// ---- hw/pbs_fifo.sv ----
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes: Head word is shown combinationally while out_valid is high.
`timescale 1ns/10ps
module pbs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PTR_W:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (PTR_W+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        wr_d = push ? PTR_W'((32'(wr_q) + 1) % DEPTH) : wr_q;
        rd_d = pop ? PTR_W'((32'(rd_q) + 1) % DEPTH) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : pbs_fifo

// ---- sim/pbs_ctrl_model.sv ----
// Purpose: Memory controller model that drives every pin of the SRAM port.
// Assumes: Pins change by non-blocking assignment at the rising edge.
// Notes: Write data trails its command by two cycles; the bench calls cyc once per clock.
`timescale 1ns/10ps
module pbs_ctrl_model (
    input wire logic clock,
    output logic [pbs_pkg::ADDR_W-1:0] address,
    output logic read_write_n,
    output logic advance_or_load,
    output logic chip_select_first_n,
    output logic chip_select_positive,
    output logic chip_select_second_n,
    output logic clock_suspend_n,
    output logic [pbs_pkg::BYTES-1:0] byte_write_enable_n,
    output logic burst_order_select_n,
    output logic [pbs_pkg::DATA_W-1:0] data_in
);
    import pbs_pkg::*;
    logic order_n = 1'b0;
    logic wburst = 1'b0;
    logic wv0 = 1'b0;
    logic wv1 = 1'b0;
    logic [DATA_W-1:0] wd0 = '0;
    logic [DATA_W-1:0] wd1 = '0;
    initial begin
        {address, read_write_n, advance_or_load, byte_write_enable_n} = '1;
        {chip_select_first_n, chip_select_positive, chip_select_second_n} = 3'h5;
        clock_suspend_n = 1'b0;
        burst_order_select_n = 1'b0;
        data_in = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // data two cycles later
    always @(posedge clock) begin
        wv1 <= wv0;
        wd1 <= wd0;
        // Idle data lines toggle so a stale word never looks valid.
        data_in <= wv1 ? wd1 : ~data_in;
    end
    task automatic cyc(input logic ld_n, input logic rw_n, input logic [2:0] sel_n, input logic sus,
                       input logic [ADDR_W-1:0] a, input logic [BYTES-1:0] be, input logic [DATA_W-1:0] wd);
        logic go;
        @(posedge clock);
        go = (sel_n == 3'h0) && !sus;
        if (go && !ld_n) wburst = !rw_n;
        if (sel_n != 3'h0) wburst = 1'b0;
        advance_or_load <= ld_n;
        read_write_n <= rw_n;
        chip_select_first_n <= sel_n[2];
        chip_select_positive <= ~sel_n[1];
        chip_select_second_n <= sel_n[0];
        clock_suspend_n <= sus;
        address <= a;
        byte_write_enable_n <= be;
        burst_order_select_n <= order_n;
        wv0 <= go && wburst;
        wd0 <= wd;
    endtask : cyc
endmodule : pbs_ctrl_model

// ---- sim/tb_pipelined_burst_sram_port.sv ----
// Purpose: Self-checking bench for the pipelined burst SRAM port.
// Assumes: The controller model drives all pins; a monitor logs every driven read word.
// Notes: Pin-level read latency is five edges, two of them spent in the synchronisers.
`timescale 1ns/10ps
module tb_pipelined_burst_sram_port;
    import pbs_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] address;
    logic read_write_n, advance_or_load, chip_select_first_n, chip_select_positive;
    logic chip_select_second_n, clock_suspend_n, burst_order_select_n, data_out_en;
    logic [BYTES-1:0] byte_write_enable_n;
    logic [DATA_W-1:0] data_in, data_out;
    logic [DATA_W-1:0] rq[$];
    logic [DATA_W-1:0] w[4];
    int rt[$];
    int cyc_n = 0;
    int num_errors = 0;
    int n_compared = 0;
    // Two synchroniser edges plus the edge at which the monitor samples the output.
    localparam int PIN_LAT = DATA_LATENCY + 3;
    always #(CLK_PERIOD_NS / 2.0) clock = ~clock;
    pbs_sram_port pbs_sram_port_i (.clock(clock), .rst(rst), .address(address), .read_write_n(read_write_n),
        .advance_or_load(advance_or_load), .chip_select_first_n(chip_select_first_n),
        .chip_select_positive(chip_select_positive), .chip_select_second_n(chip_select_second_n),
        .clock_suspend_n(clock_suspend_n), .byte_write_enable_n(byte_write_enable_n),
        .burst_order_select_n(burst_order_select_n), .data_in(data_in), .data_out(data_out),
        .data_out_en(data_out_en));
    pbs_ctrl_model pbs_ctrl_model_i (.clock(clock), .address(address), .read_write_n(read_write_n),
        .advance_or_load(advance_or_load), .chip_select_first_n(chip_select_first_n),
        .chip_select_positive(chip_select_positive), .chip_select_second_n(chip_select_second_n),
        .clock_suspend_n(clock_suspend_n), .byte_write_enable_n(byte_write_enable_n),
        .burst_order_select_n(burst_order_select_n), .data_in(data_in));
    always @(posedge clock) begin
        cyc_n <= cyc_n + 1;
        if (data_out_en === 1'b1) begin
            rq.push_back(data_out);
            rt.push_back(cyc_n);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic chk_word(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t read word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_int(int got, int exp);
        n_compared++;
        if (got != exp) begin
            num_errors++;
            $display("[FAIL] %0t count or edge %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_int
    task automatic ld(logic rw_n, logic [ADDR_W-1:0] a, logic [BYTES-1:0] be, logic [DATA_W-1:0] wd);
        pbs_ctrl_model_i.cyc(1'b0, rw_n, 3'h0, 1'b0, a, be, wd);
    endtask : ld
    // Advances carry an all-ones address so that a burst reading the pins is caught.
    task automatic adv(logic rw_n, logic [BYTES-1:0] be, logic [DATA_W-1:0] wd);
        pbs_ctrl_model_i.cyc(1'b1, rw_n, 3'h0, 1'b0, '1, be, wd);
    endtask : adv
    task automatic idle(int n);
        repeat (n) pbs_ctrl_model_i.cyc(1'b1, 1'b1, 3'h7, 1'b0, '0, 4'hf, '0);
    endtask : idle
    task automatic expect_rd(int t0, int lat, logic [DATA_W-1:0] d[$]);
        idle(8);
        chk_int(rq.size(), d.size());
        foreach (d[i]) begin
            if (i < rq.size()) begin
                chk_word(rq[i], d[i]);
                chk_int(rt[i], t0 + lat + i);
            end
        end
        rq.delete();
        rt.delete();
    endtask : expect_rd
    ////////////////////////////////////////////////////////////////////////
    task automatic s_idle();
        repeat (4) adv(1'b1, 4'hf, '0);
        idle(8);
        chk_int(rq.size(), 0);
    endtask : s_idle
    task automatic s_burst();
        int t0;
        pbs_ctrl_model_i.order_n = 1'b1;
        idle(3);
        ld(1'b0, 17'h00101, 4'h0, w[0]);
        for (int i = 1; i < 4; i++) adv(1'b1, 4'h0, w[i]);
        idle(4);
        pbs_ctrl_model_i.order_n = 1'b0;
        idle(3);
        ld(1'b1, 17'h00100, 4'hf, '0);
        t0 = cyc_n;
        for (int i = 1; i < 4; i++) adv(1'b0, 4'hf, '0);
        expect_rd(t0, PIN_LAT, {w[1], w[0], w[3], w[2]});
    endtask : s_burst
    task automatic s_bytes();
        int t0;
        logic [DATA_W-1:0] f = 36'h3_cccc_cccc;
        logic [DATA_W-1:0] n = 36'h5_5555_5555;
        logic [DATA_W-1:0] m;
        m = {f[35:9], n[8:0]};
        ld(1'b0, 17'h00200, 4'h0, f);
        idle(3);
        ld(1'b0, 17'h00200, 4'he, n);
        ld(1'b1, 17'h00100, 4'hf, '0);
        t0 = cyc_n;
        adv(1'b0, 4'h0, '0);
        ld(1'b1, 17'h00200, 4'hf, '0);
        expect_rd(t0, PIN_LAT, {w[1], w[0], m});
    endtask : s_bytes
    task automatic s_suspend();
        int t0;
        ld(1'b1, 17'h00100, 4'hf, '0);
        t0 = cyc_n;
        pbs_ctrl_model_i.cyc(1'b1, 1'b1, 3'h0, 1'b1, '1, 4'hf, '0);
        expect_rd(t0, PIN_LAT + 1, {w[1]});
    endtask : s_suspend
    task automatic s_desel();
        int t0;
        for (int i = 0; i < 3; i++) pbs_ctrl_model_i.cyc(1'b0, 1'b1, 3'h1 << i, 1'b0, 17'h00100, 4'hf, '0);
        ld(1'b1, 17'h00101, 4'hf, '0);
        t0 = cyc_n;
        idle(1);
        adv(1'b1, 4'hf, '0);
        expect_rd(t0, PIN_LAT, {w[0]});
    endtask : s_desel
    initial begin
        foreach (w[i]) w[i] = 36'h9_1234_5670 + 36'(i);
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        idle(3);
        s_idle();
        s_burst();
        s_bytes();
        s_suspend();
        s_desel();
        end_of_test();
    end
    initial begin
        #5000;
        num_errors++;
        end_of_test();
    end
endmodule : tb_pipelined_burst_sram_port
